/* hdl/hmp_pkg.sv */
// Constants shared by the host message port and its boot engine.
package hmp_pkg;

  // ************************************************************
  // Port register addresses and flag positions.
  // ************************************************************
  localparam logic [1:0] ADDR_MSG     = 2'h0;
  localparam logic [1:0] ADDR_CTRL    = 2'h1;
  localparam logic [1:0] ADDR_LINEAR  = 2'h2;
  localparam logic [1:0] ADDR_CODED   = 2'h3;
  localparam int         BIT_IN_BUSY  = 2;
  localparam int         BIT_OUT_RDY  = 1;
  localparam logic [7:0] BYTE_RESET   = 8'h00;

  // ************************************************************
  // Boot commands and replies.
  // ************************************************************
  localparam logic [23:0] CMD_BEGIN_DOWNLOAD   = 24'h00_0004;
  localparam logic [23:0] ACCEPT_ACKNOWLEDGE_CMD = 24'h00_0005;
  localparam logic [7:0]  REPLY_READY          = 8'h01;
  localparam logic [7:0]  IMAGE_ACCEPTED_REPLY = 8'h02;
  localparam logic [7:0]  UNKNOWN_COMMAND_REPLY = 8'hFB;
  localparam logic [7:0]  INIT_FAILURE_REPLY   = 8'hFD;
  localparam logic [7:0]  BAD_CHECKSUM_REPLY   = 8'hFF;

  // ************************************************************
  // Message lengths.
  // ************************************************************
  localparam logic [1:0]  CMD_LAST_IDX   = 2'h2;
  localparam logic [2:0]  RESP_BYTES     = 3'h6;
  localparam logic [15:0] CKSUM_BYTES    = 16'h0003;

  // Boot engine states.
  typedef enum logic [2:0] {
    HMP_CMD,
    HMP_IMAGE,
    HMP_ACK,
    HMP_HALT,
    HMP_RUN
  } hmp_boot_e;

endpackage : hmp_pkg

/* hdl/hmp_sync.sv */
// Two-flop synchroniser for a group of pin inputs.
`timescale 1ns/1ns
module hmp_sync #(
  parameter int              W       = 1,
  parameter logic [W-1:0]    RST_VAL = '0
) (
  // Clock and reset.
  input  wire logic         clk_sys,
  input  wire logic         reset,
  // Pins in, synchronised copy out.
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_sync
);

  logic [W-1:0] meta_r;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      meta_r   <= RST_VAL;
      pin_sync <= RST_VAL;
    end else begin
      meta_r   <= pin_in;
      pin_sync <= meta_r;
    end
  end

endmodule : hmp_sync

/* hdl/hmp_port.sv */
// Parallel host message port with boot download engine.
`timescale 1ns/1ns
module hmp_port #(
  parameter int IMAGE_LEN = 1024
) (
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // Host parallel bus pins.
  input  wire logic        cs_n,
  input  wire logic        wr_n,
  input  wire logic        rd_n,
  input  wire logic [1:0]  reg_addr,
  input  wire logic [7:0]  data_in,
  output logic      [7:0]  data_out,
  output logic             data_oe,
  output logic             attention_request_n,
  // Processor side: incoming run-time message bytes.
  output logic             proc_rx_valid,
  output logic      [7:0]  proc_rx_data,
  input  wire logic        proc_rx_take,
  input  wire logic        isr_active,
  // Processor side: six-byte run-time responses.
  input  wire logic        resp_valid,
  input  wire logic [47:0] resp_msg,
  output logic             resp_ready,
  // Processor side: status and control.
  input  wire logic        init_fail,
  input  wire logic        notify_en,
  output logic             app_start,
  output logic             app_running,
  // Audio data register writes.
  output logic             linear_audio_wr,
  output logic             coded_audio_wr,
  output logic      [7:0]  audio_data
);

  // ************************************************************
  // Pin synchronisation and strobe edges.
  // ************************************************************
  logic        cs_s, wr_s, rd_s;
  logic [1:0]  addr_s;
  logic [7:0]  din_s;
  logic        wr_d_r, rd_d_r;
  logic [1:0]  wa_r, ra_r;
  logic [7:0]  wd_r;
  logic        wr_end, rd_end, msg_wr, msg_rd;

  hmp_sync #(.W(13), .RST_VAL(13'h1_F00)) u_sync (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .pin_in   ({cs_n, wr_n, rd_n, reg_addr, data_in}),
    .pin_sync ({cs_s, wr_s, rd_s, addr_s, din_s})
  );

  // Address and data are caught while the strobe is low, so the
  // rising strobe edge commits what was on the bus in its setup time.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wr_d_r <= 1'b1;
      rd_d_r <= 1'b1;
      wa_r   <= 2'h0;
      ra_r   <= 2'h0;
      wd_r   <= hmp_pkg::BYTE_RESET;
    end else begin
      wr_d_r <= wr_s | cs_s;
      rd_d_r <= rd_s | cs_s;
      if (!cs_s && !wr_s) begin
        wa_r <= addr_s;
        wd_r <= din_s;
      end
      if (!cs_s && !rd_s) begin
        ra_r <= addr_s;
      end
    end
  end

  assign wr_end = !wr_d_r && (wr_s || cs_s);
  assign rd_end = !rd_d_r && (rd_s || cs_s);
  assign msg_wr = wr_end && (wa_r == hmp_pkg::ADDR_MSG);
  assign msg_rd = rd_end && (ra_r == hmp_pkg::ADDR_MSG);

  // ************************************************************
  // Message registers and handshake flags.
  // ************************************************************
  hmp_pkg::hmp_boot_e state_r;
  logic [7:0]  in_byte_r, out_byte_r;
  logic        in_busy_r, out_rdy_r;
  logic        boot_take, consume, reply_go;
  logic [7:0]  reply_code;
  logic [2:0]  tx_left_r;
  logic [39:0] tx_rest_r;

  // Boot engine swallows bytes itself; a halted engine never does.
  assign boot_take = in_busy_r && (state_r != hmp_pkg::HMP_RUN)
                     && (state_r != hmp_pkg::HMP_HALT);
  assign proc_rx_valid = in_busy_r && (state_r == hmp_pkg::HMP_RUN)
                         && !isr_active;
  assign proc_rx_data  = in_byte_r;
  assign consume = boot_take || (proc_rx_valid && proc_rx_take);

  // A host write in the same cycle as a consume keeps busy set.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      in_busy_r <= 1'b0;
      in_byte_r <= hmp_pkg::BYTE_RESET;
    end else if (msg_wr) begin
      in_busy_r <= 1'b1;
      in_byte_r <= wd_r;
    end else if (consume) begin
      in_busy_r <= 1'b0;
    end
  end

  // Outgoing byte: boot replies or run-time responses serialised
  // most significant byte first, always six bytes per response.
  // A new response waits until the host has read the last byte, so
  // an unread response byte is never overwritten.
  assign resp_ready = (state_r == hmp_pkg::HMP_RUN) && (tx_left_r == 3'h0)
                      && !out_rdy_r;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      out_rdy_r  <= 1'b0;
      out_byte_r <= hmp_pkg::BYTE_RESET;
      tx_left_r  <= 3'h0;
      tx_rest_r  <= '0;
    end else if (reply_go) begin
      out_byte_r <= reply_code;
      out_rdy_r  <= 1'b1;
    end else if (resp_valid && resp_ready) begin
      out_byte_r <= resp_msg[47:40];
      tx_rest_r  <= resp_msg[39:0];
      tx_left_r  <= hmp_pkg::RESP_BYTES - 3'h1;
      out_rdy_r  <= 1'b1;
    end else if (msg_rd) begin
      out_rdy_r  <= 1'b0;
    end else if (!out_rdy_r && tx_left_r != 3'h0) begin
      out_byte_r <= tx_rest_r[39:32];
      tx_rest_r  <= {tx_rest_r[31:0], 8'h00};
      tx_left_r  <= tx_left_r - 3'h1;
      out_rdy_r  <= 1'b1;
    end
  end

  // ************************************************************
  // Host read path and audio data registers.
  // ************************************************************
  logic [7:0] ctrl_byte;

  always_comb begin
    ctrl_byte = hmp_pkg::BYTE_RESET;
    ctrl_byte[hmp_pkg::BIT_IN_BUSY] = in_busy_r;
    ctrl_byte[hmp_pkg::BIT_OUT_RDY] = out_rdy_r;
  end

  // Audio registers are write only and read back as zero.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      data_out <= hmp_pkg::BYTE_RESET;
    end else begin
      case (addr_s)
        hmp_pkg::ADDR_MSG:  data_out <= out_byte_r;
        hmp_pkg::ADDR_CTRL: data_out <= ctrl_byte;
        default:            data_out <= hmp_pkg::BYTE_RESET;
      endcase
    end
  end

  assign data_oe = !cs_s && !rd_s && !rd_d_r;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      linear_audio_wr <= 1'b0;
      coded_audio_wr  <= 1'b0;
      audio_data      <= hmp_pkg::BYTE_RESET;
    end else begin
      linear_audio_wr <= wr_end && (wa_r == hmp_pkg::ADDR_LINEAR);
      coded_audio_wr  <= wr_end && (wa_r == hmp_pkg::ADDR_CODED);
      if (wr_end) begin
        audio_data <= wd_r;
      end
    end
  end

  // Boot replies stay silent on the attention line.
  assign attention_request_n = !((state_r == hmp_pkg::HMP_RUN)
                                 && notify_en && out_rdy_r);

  // ************************************************************
  // Boot engine.
  // ************************************************************
  logic [1:0]  cmd_idx_r;
  logic [15:0] cmd_hi_r;
  logic [23:0] cmd_word;
  logic [15:0] img_cnt_r;
  logic [23:0] sum_r, ck_r;

  assign cmd_word = {cmd_hi_r, in_byte_r};
  assign app_running = (state_r == hmp_pkg::HMP_RUN);

  always_comb begin
    reply_go   = 1'b0;
    reply_code = hmp_pkg::BYTE_RESET;
    if (boot_take && state_r == hmp_pkg::HMP_CMD
        && cmd_idx_r == hmp_pkg::CMD_LAST_IDX) begin
      reply_go = 1'b1;
      if (cmd_word != hmp_pkg::CMD_BEGIN_DOWNLOAD) begin
        reply_code = hmp_pkg::UNKNOWN_COMMAND_REPLY;
      end else if (init_fail) begin
        reply_code = hmp_pkg::INIT_FAILURE_REPLY;
      end else begin
        reply_code = hmp_pkg::REPLY_READY;
      end
    end else if (boot_take && state_r == hmp_pkg::HMP_IMAGE
                 && img_cnt_r == 16'(IMAGE_LEN) + hmp_pkg::CKSUM_BYTES - 16'h1) begin
      reply_go = 1'b1;
      if ({ck_r[15:0], in_byte_r} == sum_r) begin
        reply_code = hmp_pkg::IMAGE_ACCEPTED_REPLY;
      end else begin
        reply_code = hmp_pkg::BAD_CHECKSUM_REPLY;
      end
    end else if (boot_take && state_r == hmp_pkg::HMP_ACK
                 && cmd_idx_r == hmp_pkg::CMD_LAST_IDX
                 && cmd_word != hmp_pkg::ACCEPT_ACKNOWLEDGE_CMD) begin
      reply_go   = 1'b1;
      reply_code = hmp_pkg::UNKNOWN_COMMAND_REPLY;
    end
  end

  // Command bytes build MSB first; the image sums all bytes ahead
  // of the trailing checksum, modulo 2^24.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_r   <= hmp_pkg::HMP_CMD;
      cmd_idx_r <= 2'h0;
      cmd_hi_r  <= 16'h0000;
      img_cnt_r <= 16'h0000;
      sum_r     <= 24'h00_0000;
      ck_r      <= 24'h00_0000;
      app_start <= 1'b0;
    end else begin
      app_start <= 1'b0;
      case (state_r)
        hmp_pkg::HMP_CMD, hmp_pkg::HMP_ACK: begin
          if (boot_take) begin
            cmd_hi_r  <= {cmd_hi_r[7:0], in_byte_r};
            cmd_idx_r <= (cmd_idx_r == hmp_pkg::CMD_LAST_IDX) ? 2'h0 : cmd_idx_r + 2'h1;
            if (cmd_idx_r == hmp_pkg::CMD_LAST_IDX) begin
              if (reply_go && reply_code != hmp_pkg::REPLY_READY) begin
                state_r <= hmp_pkg::HMP_HALT;
              end else if (state_r == hmp_pkg::HMP_CMD) begin
                state_r <= hmp_pkg::HMP_IMAGE;
              end else begin
                state_r   <= hmp_pkg::HMP_RUN;
                app_start <= 1'b1;
              end
            end
          end
        end
        hmp_pkg::HMP_IMAGE: begin
          if (boot_take) begin
            img_cnt_r <= img_cnt_r + 16'h1;
            if (img_cnt_r < 16'(IMAGE_LEN)) begin
              sum_r <= sum_r + {16'h0000, in_byte_r};
            end else begin
              ck_r <= {ck_r[15:0], in_byte_r};
            end
            if (reply_go) begin
              state_r <= (reply_code == hmp_pkg::IMAGE_ACCEPTED_REPLY)
                         ? hmp_pkg::HMP_ACK : hmp_pkg::HMP_HALT;
            end
          end
        end
        hmp_pkg::HMP_HALT: state_r <= hmp_pkg::HMP_HALT;
        hmp_pkg::HMP_RUN:  state_r <= hmp_pkg::HMP_RUN;
        default:           state_r <= hmp_pkg::HMP_HALT;
      endcase
    end
  end

  // ************************************************************
  // Checks.
  // ************************************************************
  sequence s_begin_ok;
    boot_take && state_r == hmp_pkg::HMP_CMD && cmd_idx_r == hmp_pkg::CMD_LAST_IDX
      && cmd_word == hmp_pkg::CMD_BEGIN_DOWNLOAD && !init_fail;
  endsequence

  sequence s_ready_shown;
    out_rdy_r && out_byte_r == hmp_pkg::REPLY_READY && state_r == hmp_pkg::HMP_IMAGE;
  endsequence

  a_busy_on_write: assert property (@(posedge clk_sys) disable iff (reset)
    msg_wr |=> in_busy_r) else $error("input busy not set by write");

  a_ready_reply: assert property (@(posedge clk_sys) disable iff (reset)
    s_begin_ok |=> s_ready_shown) else $error("ready reply missing");

  a_boot_quiet: assert property (@(posedge clk_sys) disable iff (reset)
    state_r != hmp_pkg::HMP_RUN |-> attention_request_n)
    else $error("attention raised during boot");

  a_irq_mirror: assert property (@(posedge clk_sys) disable iff (reset)
    (app_running && notify_en) |-> (attention_request_n == !out_rdy_r))
    else $error("attention does not mirror ready");

  a_isr_holds: assert property (@(posedge clk_sys) disable iff (reset)
    (app_running && isr_active && in_busy_r && !msg_wr) |=> in_busy_r)
    else $error("byte taken during interrupt service");

  a_ctrl_read: assert property (@(posedge clk_sys) disable iff (reset)
    addr_s == hmp_pkg::ADDR_CTRL |=> data_out == {5'h00, $past(in_busy_r),
                                                  $past(out_rdy_r), 1'b0})
    else $error("control register value wrong");

  a_six_bytes: assert property (@(posedge clk_sys) disable iff (reset)
    (resp_valid && resp_ready) |=> tx_left_r == 3'h5 && out_rdy_r)
    else $error("response not six bytes");

  a_halt_stays: assert property (@(posedge clk_sys) disable iff (reset)
    state_r == hmp_pkg::HMP_HALT |=> state_r == hmp_pkg::HMP_HALT && !app_start)
    else $error("left halt without reset");

  a_ack_start: assert property (@(posedge clk_sys) disable iff (reset)
    app_start |-> app_running && $past(state_r) == hmp_pkg::HMP_ACK)
    else $error("start without acknowledge");

  a_unread_only: assert property (@(posedge clk_sys) disable iff (reset)
    addr_s[1] |=> data_out == 8'h00) else $error("audio register readable");

endmodule : hmp_port

/* tb/hmp_host.sv */
// Host microcontroller model for the parallel message port.
`timescale 1ns/1ns
module hmp_host (
  // Clock.
  input  wire logic       clk_sys,
  // Parallel bus pins and the host's own data drive.
  output logic            cs_n,
  output logic            wr_n,
  output logic            rd_n,
  output logic      [1:0] reg_addr,
  output logic      [7:0] host_d,
  output logic            host_oe,
  input  wire logic [7:0] bus
);
  // ******************************
  // Bus cycles.
  // ******************************
  int hold   = 6; // Strobe length; a larger value acts as a slow host.
  int stalls = 0;

  // Strobe pins idle high from time zero.
  initial begin
    cs_n     = 1'b1;
    wr_n     = 1'b1;
    rd_n     = 1'b1;
    reg_addr = 2'h0;
    host_d   = 8'h00;
    host_oe  = 1'b0;
  end

  // One strobe; every pin stands still until the answer is taken at release.
  task automatic cyc(input logic wr, input logic [1:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge clk_sys);
    reg_addr <= a;
    host_d   <= d;
    host_oe  <= wr;
    cs_n     <= 1'b0;
    wr_n     <= !wr;
    rd_n     <= wr;
    repeat (hold) @(posedge clk_sys);
    q = bus;
    cs_n    <= 1'b1;
    wr_n    <= 1'b1;
    rd_n    <= 1'b1;
    host_oe <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask : cyc

  // Poll a handshake bit; a device that never answers is counted after 300 polls, not waited on forever.
  task automatic poll(input int b, input logic lvl);
    logic [7:0] q;
    int         n = 0;
    do begin
      cyc(1'b0, hmp_pkg::ADDR_CTRL, 8'h00, q);
      n++;
    end while (q[b] !== lvl && n < 300);
    if (q[b] !== lvl) stalls++;
  endtask : poll

  // Write one message byte once the device is free to take it.
  task automatic put_byte(input logic [7:0] d);
    logic [7:0] q;
    poll(hmp_pkg::BIT_IN_BUSY, 1'b0);
    cyc(1'b1, hmp_pkg::ADDR_MSG, d, q);
  endtask : put_byte

  // Read one message byte once the device has one ready.
  task automatic get_byte(output logic [7:0] d);
    poll(hmp_pkg::BIT_OUT_RDY, 1'b1);
    cyc(1'b0, hmp_pkg::ADDR_MSG, 8'h00, d);
  endtask : get_byte

  // Commands leave as three bytes, most significant first.
  task automatic send_cmd(input logic [23:0] c);
    for (int i = 2; i >= 0; i--) begin
      put_byte(c[i*8 +: 8]);
    end
  endtask : send_cmd
endmodule : hmp_host

/* tb/hmp_port_tb.sv */
// Self-checking testbench for the host message port.
`timescale 1ns/1ns
module hmp_port_tb;
  // ******************************
  // Wiring, design and host model.
  // ******************************
  logic        clk_sys, reset, cs_n, wr_n, rd_n, host_oe, data_oe;
  logic        attention_request_n, proc_rx_valid, proc_rx_take, isr_active;
  logic        resp_valid, resp_ready, init_fail, notify_en, app_start;
  logic        app_running, linear_audio_wr, coded_audio_wr;
  logic [1:0]  reg_addr;
  logic [7:0]  host_d, bus, data_out, proc_rx_data, audio_data, aud_seen;
  logic [7:0]  last_bus = 8'h00;
  logic [47:0] resp_msg;
  int          n_errors = 0, comparisons = 0, n_start = 0, n_lin = 0, n_cod = 0;

  // A released data bus shows the inverse of its last level, never a stale copy.
  assign bus = (data_oe === 1'b1) ? data_out : host_oe ? host_d : ~last_bus;
  always @(posedge clk_sys) if (data_oe === 1'b1 || host_oe) last_bus <= bus;

  hmp_port #(.IMAGE_LEN(8)) dut_u (
    .clk_sys(clk_sys), .reset(reset), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
    .reg_addr(reg_addr), .data_in(bus), .data_out(data_out), .data_oe(data_oe),
    .attention_request_n(attention_request_n), .proc_rx_valid(proc_rx_valid),
    .proc_rx_data(proc_rx_data), .proc_rx_take(proc_rx_take),
    .isr_active(isr_active), .resp_valid(resp_valid), .resp_msg(resp_msg),
    .resp_ready(resp_ready), .init_fail(init_fail), .notify_en(notify_en),
    .app_start(app_start), .app_running(app_running),
    .linear_audio_wr(linear_audio_wr), .coded_audio_wr(coded_audio_wr),
    .audio_data(audio_data));

  hmp_host host_u (.clk_sys(clk_sys), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
    .reg_addr(reg_addr), .host_d(host_d), .host_oe(host_oe), .bus(bus));

  // Pulses last one cycle, so they are counted at every edge.
  always @(posedge clk_sys) begin
    if (app_start === 1'b1) n_start++;
    if (linear_audio_wr === 1'b1) n_lin++;
    if (coded_audio_wr === 1'b1) n_cod++;
    if (linear_audio_wr === 1'b1 || coded_audio_wr === 1'b1) aud_seen = audio_data;
  end

  // Clock at 10 MHz.
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // Compare tasks: one for bytes, one for flags.
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk8

  task automatic chk1(input string nm, input logic e, input logic g);
    chk8(nm, {7'h00, e}, {7'h00, g});
  endtask : chk1

  task automatic end_sim();
    if (n_errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim

  // ******************************
  // Scenarios.
  // ******************************
  task automatic do_reset();
    reset <= 1'b1;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask : do_reset

  // A halted device never consumes a byte, so busy stays up.
  task automatic t_halt();
    logic [7:0] q;
    host_u.cyc(1'b1, hmp_pkg::ADDR_MSG, 8'h55, q);
    repeat (20) @(posedge clk_sys);
    host_u.cyc(1'b0, hmp_pkg::ADDR_CTRL, 8'h00, q);
    chk1("busy halted", 1'b1, q[hmp_pkg::BIT_IN_BUSY]);
  endtask : t_halt

  task automatic t_reset_vals();
    logic [7:0] q;
    host_u.cyc(1'b0, hmp_pkg::ADDR_CTRL, 8'h00, q);
    chk1("busy at reset", 1'b0, q[hmp_pkg::BIT_IN_BUSY]);
    chk1("ready at reset", 1'b0, q[hmp_pkg::BIT_OUT_RDY]);
    chk1("attention at reset", 1'b1, attention_request_n);
  endtask : t_reset_vals

  task automatic t_bad_cmd();
    logic [7:0] q;
    notify_en <= 1'b1;
    host_u.send_cmd(24'h00_0003);
    host_u.poll(hmp_pkg::BIT_OUT_RDY, 1'b1);
    chk1("attention in boot", 1'b1, attention_request_n);
    host_u.cyc(1'b0, hmp_pkg::ADDR_MSG, 8'h00, q);
    chk8("unknown reply", hmp_pkg::UNKNOWN_COMMAND_REPLY, q);
    t_halt();
  endtask : t_bad_cmd

  // Eight image bytes, then their 24-bit sum plus a deliberate offset.
  task automatic send_image(input logic [23:0] delta);
    logic [23:0] sum;
    logic [7:0]  b;
    sum = 24'h00_0000;
    for (int i = 0; i < 8; i++) begin
      b = 8'hC3 ^ 8'(i * 37);
      sum = sum + 24'(b);
      host_u.put_byte(b);
    end
    host_u.send_cmd(sum + delta);
  endtask : send_image

  task automatic t_boot();
    logic [7:0] q;
    do_reset();
    init_fail <= 1'b1;
    host_u.send_cmd(hmp_pkg::CMD_BEGIN_DOWNLOAD);
    host_u.get_byte(q);
    chk8("init reply", hmp_pkg::INIT_FAILURE_REPLY, q);
    init_fail <= 1'b0;
    do_reset();
    host_u.send_cmd(hmp_pkg::CMD_BEGIN_DOWNLOAD);
    host_u.get_byte(q);
    chk8("ready reply", hmp_pkg::REPLY_READY, q);
    send_image(24'h00_0001);
    host_u.get_byte(q);
    chk8("checksum reply", hmp_pkg::BAD_CHECKSUM_REPLY, q);
    t_halt();
    do_reset();
    host_u.send_cmd(hmp_pkg::CMD_BEGIN_DOWNLOAD);
    host_u.get_byte(q);
    chk8("ready reply", hmp_pkg::REPLY_READY, q);
    send_image(24'h00_0000);
    host_u.get_byte(q);
    chk8("boot reply", hmp_pkg::IMAGE_ACCEPTED_REPLY, q);
    chk1("running early", 1'b0, app_running);
    host_u.send_cmd(hmp_pkg::ACCEPT_ACKNOWLEDGE_CMD);
    repeat (5) @(posedge clk_sys);
    chk8("start pulses", 8'h01, 8'(n_start));
    chk1("running", 1'b1, app_running);
  endtask : t_boot

  task automatic t_run();
    logic [7:0] q;
    repeat (50000) @(posedge clk_sys);
    isr_active <= 1'b1;
    host_u.put_byte(8'h9E);
    repeat (20) @(posedge clk_sys);
    chk1("rx valid in isr", 1'b0, proc_rx_valid);
    host_u.cyc(1'b0, hmp_pkg::ADDR_CTRL, 8'h00, q);
    chk1("busy in isr", 1'b1, q[hmp_pkg::BIT_IN_BUSY]);
    isr_active <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk1("rx valid", 1'b1, proc_rx_valid);
    chk8("rx data", 8'h9E, proc_rx_data);
    proc_rx_take <= 1'b1;
    @(posedge clk_sys);
    proc_rx_take <= 1'b0;
    host_u.cyc(1'b0, hmp_pkg::ADDR_CTRL, 8'h00, q);
    chk1("busy after take", 1'b0, q[hmp_pkg::BIT_IN_BUSY]);
  endtask : t_run

  task automatic t_resp();
    logic [47:0] m;
    logic [7:0]  q;
    int          n = 0;
    m = 48'hA1B2_C3D4_E5F6;
    host_u.hold = 10;
    resp_msg   <= m;
    resp_valid <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (resp_ready !== 1'b1 && n < 100);
    chk1("resp taken", 1'b1, resp_ready);
    resp_valid <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk1("attention low", 1'b0, attention_request_n);
    for (int i = 0; i < 6; i++) begin
      host_u.get_byte(q);
      chk8("resp byte", m[47 - i*8 -: 8], q);
    end
    repeat (1000) @(posedge clk_sys);
    host_u.cyc(1'b0, hmp_pkg::ADDR_CTRL, 8'h00, q);
    chk1("ready after six", 1'b0, q[hmp_pkg::BIT_OUT_RDY]);
    chk1("attention high", 1'b1, attention_request_n);
  endtask : t_resp

  task automatic t_audio();
    logic [7:0] q;
    host_u.cyc(1'b1, hmp_pkg::ADDR_LINEAR, 8'hA5, q);
    repeat (3) @(posedge clk_sys);
    chk8("linear writes", 8'h01, 8'(n_lin));
    chk8("linear data", 8'hA5, aud_seen);
    host_u.cyc(1'b1, hmp_pkg::ADDR_CODED, 8'h5A, q);
    repeat (3) @(posedge clk_sys);
    chk8("coded writes", 8'h01, 8'(n_cod));
    chk8("coded data", 8'h5A, aud_seen);
    host_u.cyc(1'b0, hmp_pkg::ADDR_LINEAR, 8'h00, q);
    chk8("linear read", 8'h00, q);
  endtask : t_audio

  // A wrong word where the acknowledge belongs is refused and halts.
  task automatic t_bad_ack();
    logic [7:0] q;
    do_reset();
    host_u.send_cmd(hmp_pkg::CMD_BEGIN_DOWNLOAD);
    host_u.get_byte(q);
    chk8("ready reply", hmp_pkg::REPLY_READY, q);
    send_image(24'h00_0000);
    host_u.get_byte(q);
    chk8("boot reply", hmp_pkg::IMAGE_ACCEPTED_REPLY, q);
    host_u.send_cmd(hmp_pkg::CMD_BEGIN_DOWNLOAD);
    host_u.get_byte(q);
    chk8("bad ack reply", hmp_pkg::UNKNOWN_COMMAND_REPLY, q);
    chk1("running after bad ack", 1'b0, app_running);
    chk8("start after bad ack", 8'h01, 8'(n_start));
    t_halt();
  endtask : t_bad_ack

  // Main sequence; every input has a level at time zero.
  initial begin
    reset        = 1'b1;
    proc_rx_take = 1'b0;
    isr_active   = 1'b0;
    resp_valid   = 1'b0;
    resp_msg     = 48'h0000_0000_0000;
    init_fail    = 1'b0;
    notify_en    = 1'b0;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (3) @(posedge clk_sys);
    t_reset_vals();
    t_bad_cmd();
    t_boot();
    t_run();
    t_resp();
    t_audio();
    t_bad_ack();
    chk8("host stalls", 8'h00, 8'(host_u.stalls));
    end_sim();
  end

  // The run needs some 55,000 cycles; a hang is cut off at 90,000.
  initial begin
    repeat (90000) @(posedge clk_sys);
    n_errors++;
    end_sim();
  end
endmodule : hmp_port_tb
